//--- design/mailbox_doorbell_unit.sv
// Mailbox doorbell unit: sixteen shared byte registers with doorbell events
`timescale 1ns/10ps
`default_nettype none
module mailbox_doorbell_unit
    import mbx_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    input wire logic [7:0] PCI_ADDR_I,
    input wire logic [LANES-1:0] PCI_BE_I,
    input wire logic PCI_RD_I,
    input wire logic PCI_WR_I,
    input wire logic [BUS_WIDTH-1:0] PCI_WDATA_I,
    output logic [BUS_WIDTH-1:0] PCI_RDATA_O,
    output logic PCI_ACK_O,
    input wire logic [31:0] DSP_ADDR_I,
    input wire logic DSP_RD_I,
    input wire logic DSP_WR_I,
    input wire logic [BUS_WIDTH-1:0] DSP_WDATA_I,
    output logic [BUS_WIDTH-1:0] DSP_RDATA_O,
    output logic DSP_ACK_O,
    input wire logic [MBX_COUNT-1:0] DB_EN_PCI_RD_I,
    input wire logic [MBX_COUNT-1:0] DB_EN_PCI_WR_I,
    input wire logic [MBX_COUNT-1:0] DB_EN_DSP_RD_I,
    input wire logic [MBX_COUNT-1:0] DB_EN_DSP_WR_I,
    input wire logic [MBX_COUNT-1:0] READ_EVENT_CLR_I,
    input wire logic [MBX_COUNT-1:0] WRITE_EVENT_CLR_I,
    input wire logic [31:0] PCI_INT_CFG_I,
    output logic [MBX_COUNT-1:0] MAILBOX_READ_EVENT_LATCH_O,
    output logic [MBX_COUNT-1:0] MAILBOX_WRITE_EVENT_LATCH_O,
    output logic DSP_INTERRUPT_LINE_O,
    output logic PCI_INT_O
);

    typedef struct packed {
        logic [MBX_COUNT-1:0][MBX_WIDTH-1:0] mbx;
        logic [BUS_WIDTH-1:0] pci_rdata;
        logic pci_ack;
        logic [BUS_WIDTH-1:0] dsp_rdata;
        logic dsp_ack;
        logic local_irq;
        logic pci_irq;
    } unit_state_t;

    unit_state_t state_reg;
    unit_state_t state_next;

    logic [MBX_COUNT-1:0] pci_hit;
    logic [MBX_COUNT-1:0] dsp_hit;
    logic [MBX_COUNT-1:0] pci_rd_hit;
    logic [MBX_COUNT-1:0] pci_wr_hit;
    logic [MBX_COUNT-1:0] dsp_rd_hit;
    logic [MBX_COUNT-1:0] dsp_wr_hit;
    logic [MBX_COUNT-1:0] read_set;
    logic [MBX_COUNT-1:0] write_set;
    logic read_any;
    logic write_any;
    logic pci_access;
    logic dsp_access;

    // A read and a write in one cycle on one port are not legal; read is ignored then
    assign pci_access = PCI_RD_I || PCI_WR_I;
    assign dsp_access = DSP_RD_I || DSP_WR_I;

    // PCI side: byte offsets within the first base region, byte enables honoured
    mbx_window_decode #(
        .ADDR_W(8),
        .WINDOW_BASE(8'h00)
    ) u_pci_decode (
        .addr_i(PCI_ADDR_I),
        .be_i(PCI_BE_I),
        .access_i(pci_access),
        .hit_o(pci_hit)
    );

    // Local bus carries whole words only, so every lane is always enabled
    mbx_window_decode #(
        .ADDR_W(32),
        .WINDOW_BASE(LOCAL_REG_WINDOW_BASE)
    ) u_dsp_decode (
        .addr_i(DSP_ADDR_I),
        .be_i({LANES{1'b1}}),
        .access_i(dsp_access),
        .hit_o(dsp_hit)
    );

    assign pci_wr_hit = PCI_WR_I ? pci_hit : '0;
    assign pci_rd_hit = (PCI_RD_I && !PCI_WR_I) ? pci_hit : '0;
    assign dsp_wr_hit = DSP_WR_I ? dsp_hit : '0;
    assign dsp_rd_hit = (DSP_RD_I && !DSP_WR_I) ? dsp_hit : '0;

    // Four doorbell kinds, each gated by its own per-mailbox enable
    assign read_set = (pci_rd_hit & DB_EN_PCI_RD_I) | (dsp_rd_hit & DB_EN_DSP_RD_I);
    assign write_set = (pci_wr_hit & DB_EN_PCI_WR_I) | (dsp_wr_hit & DB_EN_DSP_WR_I);

    mbx_event_latch u_read_events (
        .clk_i(CLK_SYS_I),
        .rst_i(SYS_RST_I),
        .set_i(read_set),
        .clr_i(READ_EVENT_CLR_I),
        .stat_o(MAILBOX_READ_EVENT_LATCH_O),
        .any_o(read_any)
    );

    mbx_event_latch u_write_events (
        .clk_i(CLK_SYS_I),
        .rst_i(SYS_RST_I),
        .set_i(write_set),
        .clr_i(WRITE_EVENT_CLR_I),
        .stat_o(MAILBOX_WRITE_EVENT_LATCH_O),
        .any_o(write_any)
    );

    always_comb begin
        state_next = state_reg;
        state_next.pci_ack = pci_access && (|pci_hit);
        state_next.dsp_ack = dsp_access && (|dsp_hit);
        state_next.pci_rdata = RDATA_RESET_VALUE;
        state_next.dsp_rdata = RDATA_RESET_VALUE;
        for (int i = 0; i < MBX_COUNT; i++) begin
            // Reads return the value held before any write of the same cycle
            if (pci_rd_hit[i]) begin
                state_next.pci_rdata[MBX_WIDTH*(i % LANES) +: MBX_WIDTH] = state_reg.mbx[i];
            end
            if (dsp_rd_hit[i]) begin
                state_next.dsp_rdata[MBX_WIDTH*(i % LANES) +: MBX_WIDTH] = state_reg.mbx[i];
            end
            // Both sides writing one byte at once: the PCI data is kept, both doorbells still fire
            if (pci_wr_hit[i]) begin
                state_next.mbx[i] = lane_byte(PCI_WDATA_I, i);
            end else if (dsp_wr_hit[i]) begin
                state_next.mbx[i] = lane_byte(DSP_WDATA_I, i);
            end
        end
        state_next.local_irq = read_any || write_any;
        state_next.pci_irq = (read_any || write_any) && PCI_INT_CFG_I[PCI_INT_CFG_MBX_EN_BIT];
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            state_reg.mbx <= {MBX_COUNT{MBX_RESET_VALUE}};
            state_reg.pci_rdata <= RDATA_RESET_VALUE;
            state_reg.pci_ack <= 1'b0;
            state_reg.dsp_rdata <= RDATA_RESET_VALUE;
            state_reg.dsp_ack <= 1'b0;
            state_reg.local_irq <= 1'b0;
            state_reg.pci_irq <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign PCI_RDATA_O = state_reg.pci_rdata;
    assign PCI_ACK_O = state_reg.pci_ack;
    assign DSP_RDATA_O = state_reg.dsp_rdata;
    assign DSP_ACK_O = state_reg.dsp_ack;
    assign DSP_INTERRUPT_LINE_O = state_reg.local_irq;
    assign PCI_INT_O = state_reg.pci_irq;

endmodule
`default_nettype wire

//--- design/mbx_pkg.sv
// Constants and helpers shared by the mailbox doorbell unit
package mbx_pkg;

    localparam int MBX_COUNT = 16;
    localparam int MBX_WIDTH = 8;
    localparam int BUS_WIDTH = 32;
    localparam int LANES = BUS_WIDTH / MBX_WIDTH;

    // Byte offsets of the mailbox block inside the internal register window
    localparam logic [7:0] MBX_FIRST_OFFSET = 8'hc0;
    localparam logic [7:0] MBX_LAST_OFFSET = 8'hcf;

    // Base of the internal register window seen from the local bus
    localparam logic [31:0] LOCAL_REG_WINDOW_BASE = 32'h1c00_0000;

    // PCI interrupt configuration: mailbox interrupt enable position
    localparam int PCI_INT_CFG_MBX_EN_BIT = 31;

    localparam logic [MBX_WIDTH-1:0] MBX_RESET_VALUE = 8'h00;
    localparam logic [MBX_COUNT-1:0] EVENT_RESET_VALUE = 16'h0000;
    localparam logic [BUS_WIDTH-1:0] RDATA_RESET_VALUE = 32'h0000_0000;

    // Byte of a bus word that serves the given mailbox register
    function automatic logic [MBX_WIDTH-1:0] lane_byte(input logic [BUS_WIDTH-1:0] word,
                                                       input int idx);
        lane_byte = word[MBX_WIDTH*(idx % LANES) +: MBX_WIDTH];
    endfunction

endpackage

//--- design/mbx_window_decode.sv
// Address decode of one access port onto the sixteen mailbox registers
`timescale 1ns/10ps
`default_nettype none
module mbx_window_decode
    import mbx_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter logic [ADDR_W-1:0] WINDOW_BASE = '0
) (
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [LANES-1:0] be_i,
    input wire logic access_i,
    output logic [MBX_COUNT-1:0] hit_o
);

    logic [ADDR_W-1:0] block_base;
    logic in_block;

    // Address bits 3:2 pick the word and the byte enables the lane; bits above 3 must match the block
    assign block_base = WINDOW_BASE + ADDR_W'(MBX_FIRST_OFFSET);
    assign in_block = access_i && (addr_i[ADDR_W-1:4] == block_base[ADDR_W-1:4]);

    always_comb begin
        for (int i = 0; i < MBX_COUNT; i++) begin
            // Each enabled lane of a wide access hits its own register
            hit_o[i] = in_block && (addr_i[3:2] == 2'(i / LANES)) && be_i[i % LANES];
        end
    end

endmodule
`default_nettype wire

//--- design/mbx_event_latch.sv
// Sticky bank of mailbox event bits, write one to clear
`timescale 1ns/10ps
`default_nettype none
module mbx_event_latch
    import mbx_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [MBX_COUNT-1:0] set_i,
    input wire logic [MBX_COUNT-1:0] clr_i,
    output logic [MBX_COUNT-1:0] stat_o,
    output logic any_o
);

    typedef struct packed {
        logic [MBX_COUNT-1:0] stat;
    } latch_state_t;

    latch_state_t state_reg;
    latch_state_t state_next;

    always_comb begin
        state_next = state_reg;
        // A new event in the clearing cycle is kept: set wins over clear
        state_next.stat = set_i | (state_reg.stat & ~clr_i);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg.stat <= EVENT_RESET_VALUE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign stat_o = state_reg.stat;
    assign any_o = |state_reg.stat;

endmodule
`default_nettype wire

//--- verif/mbx_unit_properties.sv
// Port-level checks of the mailbox doorbell unit
`timescale 1ns/10ps
`default_nettype none
module mbx_unit_properties (
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    input wire logic [7:0] PCI_ADDR_I,
    input wire logic [3:0] PCI_BE_I,
    input wire logic PCI_RD_I,
    input wire logic PCI_WR_I,
    input wire logic PCI_ACK_O,
    input wire logic [31:0] DSP_ADDR_I,
    input wire logic DSP_RD_I,
    input wire logic DSP_WR_I,
    input wire logic DSP_ACK_O,
    input wire logic [15:0] DB_EN_DSP_RD_I,
    input wire logic [15:0] READ_EVENT_CLR_I,
    input wire logic [31:0] PCI_INT_CFG_I,
    input wire logic [15:0] MAILBOX_READ_EVENT_LATCH_O,
    input wire logic [15:0] MAILBOX_WRITE_EVENT_LATCH_O,
    input wire logic DSP_INTERRUPT_LINE_O,
    input wire logic PCI_INT_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (SYS_RST_I);
    sequence pci_req; (PCI_RD_I || PCI_WR_I) && PCI_BE_I != 4'h0; endsequence
    sequence dsp_req; DSP_RD_I || DSP_WR_I; endsequence
    AST_PCI_ACK: assert property (pci_req ##0 PCI_ADDR_I[7:4] == 4'hc |=> PCI_ACK_O)
        else $error("pci ack missing");
    AST_PCI_MISS: assert property (pci_req ##0 PCI_ADDR_I[7:4] != 4'hc |=> !PCI_ACK_O)
        else $error("pci ack outside block");
    AST_DSP_ACK: assert property (dsp_req ##0 DSP_ADDR_I[31:4] == 28'h1c0000c |=> DSP_ACK_O)
        else $error("dsp ack missing");
    AST_DSP_MISS: assert property (dsp_req ##0 DSP_ADDR_I[31:4] != 28'h1c0000c |=> !DSP_ACK_O)
        else $error("dsp ack outside block");
    AST_DSP_RD_EVT: assert property (dsp_req ##0 (!DSP_WR_I && DSP_ADDR_I[31:2] == 30'h0700_0030
        && DB_EN_DSP_RD_I[3:0] == 4'hf) |=> MAILBOX_READ_EVENT_LATCH_O[3:0] == 4'hf)
        else $error("word read events missing");
    AST_RD_STICKY: assert property (READ_EVENT_CLR_I == 16'h0000 |=>
        (MAILBOX_READ_EVENT_LATCH_O & $past(MAILBOX_READ_EVENT_LATCH_O)) == $past(MAILBOX_READ_EVENT_LATCH_O))
        else $error("read event lost without clear");
    AST_DSP_IRQ: assert property (DSP_INTERRUPT_LINE_O ==
        ($past(MAILBOX_READ_EVENT_LATCH_O) != 0 || $past(MAILBOX_WRITE_EVENT_LATCH_O) != 0))
        else $error("local interrupt wrong");
    AST_PCI_IRQ: assert property (PCI_INT_O == (DSP_INTERRUPT_LINE_O && $past(PCI_INT_CFG_I[31])))
        else $error("pci interrupt wrong");
endmodule
bind mailbox_doorbell_unit mbx_unit_properties chk_u (.*);
`default_nettype wire

//--- verif/mbx_far_side.sv
// Behavioural PCI host and DSP core driving the two access ports
`timescale 1ns/10ps
`default_nettype none
module mbx_far_side (
    input wire logic CLK_SYS_I,
    input wire logic [31:0] PCI_RDATA_O,
    input wire logic PCI_ACK_O,
    input wire logic [31:0] DSP_RDATA_O,
    input wire logic DSP_ACK_O,
    output logic [7:0] PCI_ADDR_I = 8'h00,
    output logic [3:0] PCI_BE_I = 4'h0,
    output logic PCI_RD_I = 1'b0,
    output logic PCI_WR_I = 1'b0,
    output logic [31:0] PCI_WDATA_I = 32'h0,
    output logic [31:0] DSP_ADDR_I = 32'h0,
    output logic DSP_RD_I = 1'b0,
    output logic DSP_WR_I = 1'b0,
    output logic [31:0] DSP_WDATA_I = 32'h0
);
    // One-cycle request, answer sampled once the taking edge has landed
    task automatic pci(input logic w, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] d, output logic [31:0] q, output logic k);
        @(posedge CLK_SYS_I);
        #1;
        {PCI_RD_I, PCI_WR_I, PCI_ADDR_I, PCI_BE_I, PCI_WDATA_I} = {!w, w, a, be, d};
        @(posedge CLK_SYS_I);
        #1;
        {q, k} = {PCI_RDATA_O, PCI_ACK_O};
        // Released write data is inverted so a stale value cannot be mistaken for data
        {PCI_RD_I, PCI_WR_I, PCI_WDATA_I} = {2'b00, ~d};
    endtask
    // The DSP always moves a whole word across all four lanes
    task automatic dsp(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic k);
        @(posedge CLK_SYS_I);
        #1;
        {DSP_RD_I, DSP_WR_I, DSP_ADDR_I, DSP_WDATA_I} = {!w, w, a, d};
        @(posedge CLK_SYS_I);
        #1;
        {q, k} = {DSP_RDATA_O, DSP_ACK_O};
        {DSP_RD_I, DSP_WR_I, DSP_WDATA_I} = {2'b00, ~d};
    endtask
endmodule
`default_nettype wire

//--- verif/mailbox_doorbell_unit_tb.sv
// Self-checking bench for the mailbox doorbell unit
`timescale 1ns/10ps
`default_nettype none
module mailbox_doorbell_unit_tb;
    logic CLK_SYS_I = 1'b0;
    logic SYS_RST_I = 1'b1;
    logic [15:0] DB_EN_PCI_RD_I = 16'h0, DB_EN_PCI_WR_I = 16'h0;
    logic [15:0] DB_EN_DSP_RD_I = 16'h0, DB_EN_DSP_WR_I = 16'h0;
    logic [15:0] READ_EVENT_CLR_I = 16'h0, WRITE_EVENT_CLR_I = 16'h0;
    logic [31:0] PCI_INT_CFG_I = 32'h0;
    wire logic [7:0] PCI_ADDR_I;
    wire logic [3:0] PCI_BE_I;
    wire logic PCI_RD_I, PCI_WR_I, PCI_ACK_O, DSP_RD_I, DSP_WR_I, DSP_ACK_O;
    wire logic [31:0] PCI_WDATA_I, PCI_RDATA_O, DSP_ADDR_I, DSP_WDATA_I, DSP_RDATA_O;
    wire logic [15:0] MAILBOX_READ_EVENT_LATCH_O, MAILBOX_WRITE_EVENT_LATCH_O;
    wire logic DSP_INTERRUPT_LINE_O, PCI_INT_O;
    int error_cnt = 0;
    int checks_done = 0;
    logic [31:0] q;
    logic k;
    mailbox_doorbell_unit dut_u (.*);
    mbx_far_side host_u (.*);
    initial begin
        forever #4 CLK_SYS_I = ~CLK_SYS_I;
    end
    task automatic step(input int n);
        repeat (n) @(posedge CLK_SYS_I);
        #1;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic evt(input logic [31:0] e);
        chk("events", e, {MAILBOX_READ_EVENT_LATCH_O, MAILBOX_WRITE_EVENT_LATCH_O});
    endtask
    task automatic irq(input logic [31:0] e);
        chk("irq", e, {30'h0, DSP_INTERRUPT_LINE_O, PCI_INT_O});
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        step(2);
        SYS_RST_I = 1'b0;
        evt(32'h0);
        irq(32'h0);
        $display("test reset done");
        {DB_EN_PCI_WR_I, DB_EN_DSP_RD_I} = {16'hffff, 16'h000f};
        host_u.pci(1'b1, 8'hc0, 4'h3, 32'hdead_5a3c, q, k);
        chk("pci_ack", 32'h1, {31'h0, k});
        evt(32'h0000_0003);
        host_u.dsp(1'b0, 32'h1c00_00c0, 32'h0, q, k);
        chk("dsp_rdata", 32'h0000_5a3c, q);
        evt(32'h000f_0003);
        step(1);
        irq(32'h2);
        PCI_INT_CFG_I = 32'h8000_0000;
        step(2);
        irq(32'h3);
        WRITE_EVENT_CLR_I = 16'h0001;
        step(1);
        WRITE_EVENT_CLR_I = 16'h0;
        evt(32'h000f_0002);
        {READ_EVENT_CLR_I, WRITE_EVENT_CLR_I} = {16'hffff, 16'hffff};
        step(1);
        {READ_EVENT_CLR_I, WRITE_EVENT_CLR_I} = 32'h0;
        evt(32'h0);
        step(1);
        irq(32'h0);
        $display("test doorbell done");
        {DB_EN_PCI_WR_I, DB_EN_DSP_RD_I, DB_EN_PCI_RD_I, DB_EN_DSP_WR_I} = 64'h0000_0000_0fff_0fff;
        host_u.pci(1'b0, 8'hb0, 4'hf, 32'h0, q, k);
        chk("pci_miss", 32'h0, {q[31:1], q[0] | k});
        host_u.dsp(1'b0, 32'h1d00_00c0, 32'h0, q, k);
        chk("dsp_miss", 32'h0, {q[31:1], q[0] | k});
        host_u.dsp(1'b1, 32'h1c00_00cc, 32'h8877_6655, q, k);
        chk("dsp_ack", 32'h1, {31'h0, k});
        host_u.pci(1'b0, 8'hcc, 4'hf, 32'h0, q, k);
        chk("pci_rdata", 32'h8877_6655, q);
        evt(32'h0);
        host_u.pci(1'b0, 8'hc0, 4'hf, 32'h0, q, k);
        chk("pci_rdata", 32'h0000_5a3c, q);
        host_u.dsp(1'b1, 32'h1c00_00c8, 32'h0403_0201, q, k);
        evt(32'h000f_0f00);
        $display("test masks done");
        // Clear held over the taking edge of an enabled read: the new event must survive
        READ_EVENT_CLR_I = 16'hffff;
        host_u.pci(1'b0, 8'hc4, 4'h1, 32'h0, q, k);
        READ_EVENT_CLR_I = 16'h0;
        evt(32'h0010_0f00);
        $display("test set over clear done");
        wrap_up();
    end
endmodule
`default_nettype wire
